// [pkg/epa_defines.vh]
// Constants for the energy pulse and accumulation support block
`ifndef EPA_DEFINES_VH
`define EPA_DEFINES_VH
`define EPA_ACCCFG_ADDR      16'h2001
`define EPA_PRESUM_MSB       7
`define EPA_PRESUM_LSB       6
`define EPA_SUMCYC_MSB       5
`define EPA_SUMCYC_LSB       0
`define EPA_ACCCFG_RESET     8'h00
`define EPA_FIR_PERIOD_NS    203
`define EPA_MCLK_PERIOD_NS   40
`define EPA_FIR_CYCLES       ((`EPA_FIR_PERIOD_NS + `EPA_MCLK_PERIOD_NS - 1) / `EPA_MCLK_PERIOD_NS)
`define EPA_FIR_PER_UNIT     4
`define EPA_RTM_BITS         35
`define EPA_RTM_WORDS        4
`define EPA_WIDTH_NOLIMIT    8'hFF
`define EPA_EQU_ONE_ELEM     2'h0
`define EPA_EQU_SPLIT        2'h1
`define EPA_EQU_TWO_ELEM     2'h2
`define EPA_FIFO_DEPTH       8
`endif

// [hw/epa_pulse_fifo.v]
// Sign-bit FIFO that holds exported pulse updates for paced release
`include "epa_defines.vh"
module epa_pulse_fifo (
  input  wire       mclk,
  input  wire       reset,
  input  wire       clear,
  input  wire       push,
  input  wire [1:0] pushBits,
  input  wire       pop,
  output wire [1:0] popBits,
  output wire       empty,
  output wire       full
);
  // Two sign bits (real, reactive) per entry, eight entries
  reg [1:0] store [0:`EPA_FIFO_DEPTH-1];
  reg [2:0] wrPtr;        // Write index
  reg [2:0] rdPtr;        // Read index
  reg [3:0] count;        // Occupancy
  wire      doPush;
  wire      doPop;

  assign empty   = (count == 4'h0);
  assign full    = (count == 4'h8);
  assign popBits = store[rdPtr];
  // Full FIFO drops pushes, keeping pending entries
  assign doPush  = push && !full;
  assign doPop   = pop && !empty;

  // Storage write; no reset needed since pointers qualify it
  always @(posedge mclk)
  begin
    if (doPush)
      store[wrPtr] <= pushBits;
  end

  // Pointer and count update; frame clear wins over all traffic
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr <= 3'h0;
      rdPtr <= 3'h0;
      count <= 4'h0;
    end
    else if (clear)
    begin
      wrPtr <= 3'h0;
      rdPtr <= 3'h0;
      count <= 4'h0;
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + 3'h1;
      if (doPop)
        rdPtr <= rdPtr + 3'h1;
      if (doPush && !doPop)
        count <= count + 4'h1;
      else if (doPop && !doPush)
        count <= count - 4'h1;
    end
  end
endmodule

// [hw/epa_energy_pulse.v]
// Accumulation, equation select, real-time monitor and energy pulse generation
`include "epa_defines.vh"
module epa_energy_pulse (
  input  wire        mclk,
  input  wire        reset,
  input  wire        cfgWrite,
  input  wire [15:0] cfgAddr,
  input  wire [7:0]  cfgWdata,
  output reg  [7:0]  cfgRdata,
  input  wire        sampleDone,
  input  wire        muxSync,
  input  wire        ceHalt,
  input  wire        muxFrameEnd,
  input  wire [1:0]  meter_equation_select,
  input  wire signed [15:0] voltageA,
  input  wire signed [15:0] voltageB,
  input  wire signed [15:0] currentA,
  input  wire signed [15:0] currentB,
  output reg  signed [31:0] element0Product,
  output reg  signed [31:0] element1Product,
  output reg  signed [31:0] firstLevelSum,
  output reg  signed [31:0] secondLevelSum,
  output reg         accumulation_done_irq,
  output reg         frameDoneIrq,
  input  wire        monitor_enable,
  input  wire        test_clock,
  input  wire [127:0] monitorWords,
  output reg         test_mux_output,
  input  wire        external_pulse_flag,
  input  wire [31:0] real_pulse_value,
  input  wire [31:0] reactive_pulse_value,
  input  wire [31:0] pulse_rate_constant,
  input  wire [31:0] real_energy_sum,
  input  wire [31:0] reactive_energy_sum,
  output reg  [31:0] realPulseRate,
  output reg  [31:0] reactivePulseRate,
  input  wire        signExport,
  input  wire [1:0]  signBits,
  input  wire [7:0]  pulse_update_interval,
  input  wire [7:0]  pulse_width_limit,
  input  wire        pulse_polarity_invert,
  input  wire        real_pulse_route,
  input  wire        reactive_pulse_route,
  input  wire [1:0]  optical_transmit_enable,
  output reg         real_energy_pulse,
  output reg         reactive_energy_pulse,
  output reg         digitalPin6,
  output reg         digitalPin6Enable,
  output reg         digitalPin7,
  output reg         digitalPin7Enable,
  output reg         optical_transmit_pin
);
  // Presum count per code; all four (42, 50, 84, 100) are parameters
  parameter [7:0] PRESUM_CODE0 = 8'h2A;
  parameter [7:0] PRESUM_CODE1 = 8'h32;
  parameter [7:0] PRESUM_CODE2 = 8'h54;
  parameter [7:0] PRESUM_CODE3 = 8'h64;

  // Monitor shifter states, one-hot
  localparam [2:0] MON_IDLE = 3'b001;
  localparam [2:0] MON_SHIFT = 3'b010;
  localparam [2:0] MON_GAP = 3'b100;

  reg [7:0]  accumulation_config;     // Presum and cycle count byte
  reg [7:0]  presumCount;              // Samples summed so far in level one
  reg [5:0]  cycleCount;               // Level-one totals summed so far
  reg signed [31:0] levelOne;          // Running presum
  reg signed [31:0] levelTwo;          // Running summation
  reg        syncPrev;                 // Mux sync of last cycle
  reg        testPrev;                 // Test clock of last cycle
  reg        passActive;               // Code pass underway
  reg        monStart;                 // Pending monitor start request
  reg [2:0]  monState;                 // Monitor shifter state
  reg [5:0]  monBit;                   // Bit index inside word
  reg [1:0]  monWord;                  // Word index
  reg [34:0] monShift;                 // Shift register for current word
  reg [2:0]  firDiv;                   // Filter clock divider
  reg [1:0]  firUnit;                  // Filter clocks inside one interval unit
  reg [7:0]  intervalCount;            // Units left until next update
  reg [8:0]  widthCount;               // Updates the pulse has been active
  reg        realActive;               // Logical real pulse state
  reg        reactActive;              // Logical reactive pulse state
  reg        squareMode;               // Last update was a limit hit
  wire       syncRise;
  wire       testRise;
  wire       firTick;
  wire       unitTick;
  wire       fifoPop;
  wire [1:0] fifoBits;
  wire       fifoEmpty;
  wire       updateNow;
  wire [1:0] updateBits;
  wire [8:0] widthMax;
  wire       limitHit;
  wire signed [16:0] currentDiff;
  wire signed [31:0] sampleProduct;

  // Maps presum code to sample count
  function [7:0] presum_of;
    input [1:0] code;
    begin
      case (code)
        2'h0: presum_of = PRESUM_CODE0;
        2'h1: presum_of = PRESUM_CODE1;
        2'h2: presum_of = PRESUM_CODE2;
        default: presum_of = PRESUM_CODE3;
      endcase
    end
  endfunction

  // Signed 16x16 product
  function signed [31:0] mul16;
    input signed [15:0] a;
    input signed [15:0] b;
    begin
      mul16 = a * b;
    end
  endfunction

  assign syncRise = muxSync && !syncPrev;
  assign testRise = test_clock && !testPrev;
  assign firTick  = (firDiv == `EPA_FIR_CYCLES - 1);
  assign unitTick = firTick && (firUnit == `EPA_FIR_PER_UNIT - 1);
  assign sampleProduct = element0Product + element1Product;
  // Sign-extended so the difference cannot overflow before halving
  assign currentDiff = {currentA[15], currentA} - {currentB[15], currentB};
  assign widthMax = {pulse_width_limit, 1'b0} + 9'h001;
  assign limitHit = updateBits[0] && (pulse_width_limit != `EPA_WIDTH_NOLIMIT) && (widthCount >= widthMax);

  // Register access and configuration byte
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      accumulation_config <= `EPA_ACCCFG_RESET;
    else if (cfgWrite && cfgAddr == `EPA_ACCCFG_ADDR)
      accumulation_config <= cfgWdata;
  end

  // Readback mux; unmapped addresses read zero
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      cfgRdata <= 8'h00;
    else
      cfgRdata <= (cfgAddr == `EPA_ACCCFG_ADDR) ? accumulation_config : 8'h00;
  end

  // Equation select forms the element products
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      element0Product <= 32'h0000_0000;
      element1Product <= 32'h0000_0000;
    end
    else
    begin
      case (meter_equation_select)
        `EPA_EQU_ONE_ELEM:
        begin
          element0Product <= mul16(voltageA, currentA);
          element1Product <= mul16(voltageA, currentB);
        end
        `EPA_EQU_SPLIT:
        begin
          // Halved difference keeps the multiply 16 bits wide
          element0Product <= mul16(voltageA, currentDiff[16:1]);
          element1Product <= 32'h0000_0000;
        end
        `EPA_EQU_TWO_ELEM:
        begin
          element0Product <= mul16(voltageA, currentA);
          element1Product <= mul16(voltageB, currentB);
        end
        default:
        begin
          element0Product <= 32'h0000_0000;
          element1Product <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Two-level accumulation
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      presumCount <= 8'h00;
      cycleCount <= 6'h00;
      levelOne <= 32'h0000_0000;
      levelTwo <= 32'h0000_0000;
      firstLevelSum <= 32'h0000_0000;
      secondLevelSum <= 32'h0000_0000;
      accumulation_done_irq <= 1'b0;
    end
    else
    begin
      accumulation_done_irq <= 1'b0;
      if (sampleDone)
      begin
        if (presumCount + 8'h01 >= presum_of(accumulation_config[`EPA_PRESUM_MSB:`EPA_PRESUM_LSB]))
        begin
          presumCount <= 8'h00;
          levelOne <= 32'h0000_0000;
          firstLevelSum <= levelOne + sampleProduct;
          // Cycle count of zero is treated as one to avoid a stuck accumulator
          if (cycleCount + 6'h01 >= accumulation_config[`EPA_SUMCYC_MSB:`EPA_SUMCYC_LSB])
          begin
            cycleCount <= 6'h00;
            levelTwo <= 32'h0000_0000;
            secondLevelSum <= levelTwo + levelOne + sampleProduct;
            accumulation_done_irq <= 1'b1;
          end
          else
          begin
            cycleCount <= cycleCount + 6'h01;
            levelTwo <= levelTwo + levelOne + sampleProduct;
          end
        end
        else
        begin
          presumCount <= presumCount + 8'h01;
          levelOne <= levelOne + sampleProduct;
        end
      end
    end
  end

  // Frame-done interrupt and code pass tracking
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      frameDoneIrq <= 1'b0;
      syncPrev <= 1'b0;
      passActive <= 1'b0;
    end
    else
    begin
      frameDoneIrq <= muxFrameEnd;
      syncPrev <= muxSync;
      if (syncRise)
        passActive <= 1'b1;
      else if (ceHalt)
        passActive <= 1'b0;
    end
  end

  // Monitor: four 35-bit words, flag first
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      testPrev <= 1'b0;
      monStart <= 1'b0;
      monState <= MON_IDLE;
      monBit <= 6'h00;
      monWord <= 2'h0;
      monShift <= 35'h0;
      test_mux_output <= 1'b0;
    end
    else
    begin
      testPrev <= test_clock;
      if (syncRise && monitor_enable)
        monStart <= 1'b1;
      case (monState)
        MON_IDLE:
        begin
          test_mux_output <= 1'b0;
          if (monStart && testRise)
          begin
            monStart <= 1'b0;
            monWord <= 2'h0;
            monBit <= 6'h00;
            monShift <= {1'b1, 2'b00, monitorWords[31:0]};
            monState <= MON_SHIFT;
          end
        end
        MON_SHIFT:
        begin
          if (!monitor_enable)
          begin
            monState <= MON_IDLE;
            test_mux_output <= 1'b0;
          end
          else if (testRise)
          begin
            test_mux_output <= monShift[34];
            monShift <= {monShift[33:0], 1'b0};
            if (monBit == `EPA_RTM_BITS - 1)
              monState <= MON_GAP;
            else
              monBit <= monBit + 6'h01;
          end
        end
        MON_GAP:
        begin
          // The last data bit may still stand here, so disabling must clear it
          if (!monitor_enable)
          begin
            monState <= MON_IDLE;
            test_mux_output <= 1'b0;
          end
          else if (testRise)
          begin
            test_mux_output <= 1'b0;
            if (monWord == `EPA_RTM_WORDS - 1)
              monState <= MON_IDLE;
            else
            begin
              monWord <= monWord + 2'h1;
              monBit <= 6'h00;
              monShift <= {1'b1, 2'b00, monitorWords[32*(monWord+2'h1) +: 32]};
              monState <= MON_SHIFT;
            end
          end
        end
        default:
        begin
          monState <= MON_IDLE;
          test_mux_output <= 1'b0;
        end
      endcase
    end
  end

  // Pulse rate source selection
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      realPulseRate <= 32'h0000_0000;
      reactivePulseRate <= 32'h0000_0000;
    end
    else if (external_pulse_flag)
    begin
      realPulseRate <= real_pulse_value * pulse_rate_constant;
      reactivePulseRate <= reactive_pulse_value * pulse_rate_constant;
    end
    else
    begin
      realPulseRate <= real_energy_sum;
      reactivePulseRate <= reactive_energy_sum;
    end
  end

  // Filter divider and release pacing, restarted per frame
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      firDiv <= 3'h0;
      firUnit <= 2'h0;
      intervalCount <= 8'h00;
    end
    else if (syncRise)
    begin
      firDiv <= 3'h0;
      firUnit <= 2'h0;
      intervalCount <= pulse_update_interval;
    end
    else
    begin
      firDiv <= firTick ? 3'h0 : firDiv + 3'h1;
      if (firTick)
        firUnit <= firUnit + 2'h1;
      if (unitTick)
        intervalCount <= (intervalCount <= 8'h01) ? pulse_update_interval : intervalCount - 8'h01;
    end
  end

  assign fifoPop    = unitTick && (intervalCount == 8'h01) && !fifoEmpty;
  assign updateNow  = (pulse_update_interval == 8'h00) ? signExport : fifoPop;
  assign updateBits = (pulse_update_interval == 8'h00) ? signBits : fifoBits;

  epa_pulse_fifo signFifo (
    .mclk     (mclk),
    .reset    (reset),
    .clear    (syncRise),
    .push     (signExport && passActive && (pulse_update_interval != 8'h00)),
    .pushBits (signBits),
    .pop      (fifoPop),
    .popBits  (fifoBits),
    .empty    (fifoEmpty),
    .full     ()
  );

  // Width limiter: active updates counted per pulse; limit 255 means none
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      realActive <= 1'b0;
      reactActive <= 1'b0;
      widthCount <= 9'h000;
      squareMode <= 1'b0;
    end
    else if (updateNow)
    begin
      reactActive <= updateBits[1];
      // Limit conflict: real pulse forced inactive, or toggled if the last update was also a limit hit; width count restarted
      squareMode <= limitHit;
      if (limitHit)
      begin
        realActive <= squareMode ? ~realActive : 1'b0;
        widthCount <= 9'h000;
      end
      else
      begin
        realActive <= updateBits[0];
        widthCount <= updateBits[0] ? widthCount + 9'h001 : 9'h000;
      end
    end
  end

  // Pin drive with polarity and routing
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      real_energy_pulse <= 1'b1;
      reactive_energy_pulse <= 1'b1;
      digitalPin6 <= 1'b1;
      digitalPin7 <= 1'b1;
      digitalPin6Enable <= 1'b0;
      digitalPin7Enable <= 1'b0;
      optical_transmit_pin <= 1'b1;
    end
    else
    begin
      real_energy_pulse <= realActive ~^ pulse_polarity_invert;
      reactive_energy_pulse <= reactActive ~^ pulse_polarity_invert;
      digitalPin6 <= realActive ~^ pulse_polarity_invert;
      digitalPin7 <= reactActive ~^ pulse_polarity_invert;
      digitalPin6Enable <= real_pulse_route;
      digitalPin7Enable <= reactive_pulse_route;
      case (optical_transmit_enable)
        2'h1: optical_transmit_pin <= realActive ~^ pulse_polarity_invert;
        2'h2: optical_transmit_pin <= reactActive ~^ pulse_polarity_invert;
        default: optical_transmit_pin <= 1'b1;
      endcase
    end
  end
endmodule

// [verif/epa_energy_pulse_sva.sv]
// Port-level assertions for the energy pulse and accumulation block
`include "epa_defines.vh"
module epa_energy_pulse_sva (
  input wire        mclk,
  input wire        reset,
  input wire        cfgWrite,
  input wire [15:0] cfgAddr,
  input wire [7:0]  cfgWdata,
  input wire [7:0]  cfgRdata,
  input wire        sampleDone,
  input wire        accumulation_done_irq,
  input wire        muxFrameEnd,
  input wire        frameDoneIrq,
  input wire        monitor_enable,
  input wire        test_mux_output,
  input wire        signExport,
  input wire [1:0]  signBits,
  input wire [7:0]  pulse_update_interval,
  input wire [7:0]  pulse_width_limit,
  input wire        pulse_polarity_invert,
  input wire        real_pulse_route,
  input wire        reactive_pulse_route,
  input wire        digitalPin6Enable,
  input wire        digitalPin7Enable,
  input wire        real_energy_pulse,
  input wire        reactive_energy_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sign bits delayed two edges, the bypass path latency
  reg [1:0] sgnD1;
  reg [1:0] sgnD2;
  always @(posedge mclk)
  begin
    sgnD1 <= signBits;
    sgnD2 <= sgnD1;
  end
  // Readback stands one cycle after the address
  property p_cfg_write;
    @(posedge mclk) disable iff (reset)
    cfgWrite && cfgAddr == `EPA_ACCCFG_ADDR ##1 !cfgWrite && cfgAddr == `EPA_ACCCFG_ADDR
    |=> cfgRdata == $past(cfgWdata, 2);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("cfg readback");
  property p_cfg_unmapped;
    @(posedge mclk) disable iff (reset) cfgAddr != `EPA_ACCCFG_ADDR [*2] |-> cfgRdata == 8'h00;
  endproperty
  a_cfg_unmapped: assert property (p_cfg_unmapped)
    else $error("unmapped nonzero");
  property p_frame;
    @(posedge mclk) disable iff (reset) muxFrameEnd && !frameDoneIrq |=> frameDoneIrq;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame done pulse missing");
  property p_irq;
    @(posedge mclk) disable iff (reset) accumulation_done_irq |-> $past(sampleDone) ##1 !accumulation_done_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without sample");
  property p_mon_low;
    @(posedge mclk) disable iff (reset) !monitor_enable |=> !test_mux_output;
  endproperty
  a_mon_low: assert property (p_mon_low)
    else $error("monitor high disabled");
  property p_pin6;
    @(posedge mclk) disable iff (reset) real_pulse_route [*2] |-> digitalPin6Enable;
  endproperty
  a_pin6: assert property (p_pin6)
    else $error("pin6 not driven");
  property p_pin7;
    @(posedge mclk) disable iff (reset) !reactive_pulse_route [*2] |-> !digitalPin7Enable;
  endproperty
  a_pin7: assert property (p_pin7)
    else $error("pin7 driven unrouted");
  property p_bypass;
    @(posedge mclk) disable iff (reset)
    signExport && pulse_update_interval == 8'h00 && pulse_width_limit == `EPA_WIDTH_NOLIMIT && $stable(pulse_polarity_invert)
    |-> ##2 {reactive_energy_pulse, real_energy_pulse} == ~(sgnD2 ^ {2{pulse_polarity_invert}});
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass level");
  property p_reset;
    @(posedge mclk) disable iff (reset) $past(reset) && !pulse_polarity_invert |-> real_energy_pulse && reactive_energy_pulse;
  endproperty
  a_reset: assert property (p_reset)
    else $error("pulse active after reset");
endmodule

bind epa_energy_pulse epa_energy_pulse_sva epa_energy_pulse_sva_inst (.*);

// [verif/epa_pulse_meter.sv]
// Test equipment model that counts energy pulses seen on the output pins
module epa_pulse_meter (
  input  wire         mclk,
  input  wire         reset,
  input  wire         pin6,
  input  wire         pin6Enable,
  input  wire         pin7,
  input  wire         pin7Enable,
  input  wire         optPin,
  output logic [15:0] realCount,
  output logic [15:0] reactiveCount,
  output logic [15:0] optCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin reads as the board pull-up, never the last driven level
  wire  lvl6 = pin6Enable ? pin6 : 1'b1;
  wire  lvl7 = pin7Enable ? pin7 : 1'b1;
  logic last6;
  logic last7;
  logic lastOpt;
  // A pulse is one falling edge of an active-low line
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      {last6, last7, lastOpt} <= 3'h7;
      realCount <= 16'h0000;
      reactiveCount <= 16'h0000;
      optCount <= 16'h0000;
    end
    else
    begin
      {last6, last7, lastOpt} <= {lvl6, lvl7, optPin};
      if (last6 && !lvl6)
        realCount <= realCount + 16'h0001;
      if (last7 && !lvl7)
        reactiveCount <= reactiveCount + 16'h0001;
      if (lastOpt && !optPin)
        optCount <= optCount + 16'h0001;
    end
  end
endmodule

// [verif/epa_energy_pulse_test.sv]
// Self-checking bench for the energy pulse and accumulation block
`include "epa_defines.vh"
module epa_energy_pulse_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] eq; logic [15:0] va, vb, ia, ib; logic ext; logic [31:0] e0, e1, rr, qr;} epa_row_t;
  // Rows: inputs, then expected products and rates
  epa_row_t rows[3] = '{
    '{2'h0, 16'h0003, 16'h0009, 16'hFFFC, 16'h0005, 1'b1, 32'hFFFF_FFF4, 32'h0000_000F, 32'h0000_0015, 32'h0000_0023},
    '{2'h1, 16'h0006, 16'h0000, 16'h000A, 16'hFFFE, 1'b0, 32'h0000_0024, 32'h0000_0000, 32'h0000_0011, 32'h0000_0022},
    '{2'h2, 16'hFFF9, 16'h0002, 16'h0003, 16'hFED4, 1'b1, 32'hFFFF_FFEB, 32'hFFFF_FDA8, 32'h0000_0015, 32'h0000_0023}};
  logic mclk = 1'b0, reset = 1'b1, cfgWrite = 1'b0, sampleDone = 1'b0, muxSync = 1'b0, ceHalt = 1'b0, muxFrameEnd = 1'b0;
  logic monitor_enable = 1'b0, external_pulse_flag = 1'b0, signExport = 1'b0, pulse_polarity_invert = 1'b0;
  logic real_pulse_route = 1'b0, reactive_pulse_route = 1'b0;
  logic [15:0] cfgAddr = 16'h2001;
  logic [7:0] cfgWdata = 8'h00, pulse_update_interval = 8'h00, pulse_width_limit = 8'hFF;
  logic [1:0] meter_equation_select = 2'h0, signBits = 2'h0, optical_transmit_enable = 2'h1;
  logic signed [15:0] voltageA = 16'h0000, voltageB = 16'h0000, currentA = 16'h0000, currentB = 16'h0000;
  logic [127:0] monitorWords = {32'h0000_0000, 32'hF000_0000, 32'h0000_0003, 32'h8000_0001};
  logic [31:0] real_pulse_value = 32'h0000_0003, reactive_pulse_value = 32'h0000_0005, pulse_rate_constant = 32'h0000_0007;
  logic [31:0] real_energy_sum = 32'h0000_0011, reactive_energy_sum = 32'h0000_0022;
  logic [2:0] tcDiv = 3'h0;
  wire test_clock = tcDiv[2];
  wire [7:0] cfgRdata;
  wire signed [31:0] element0Product, element1Product, firstLevelSum, secondLevelSum;
  wire [31:0] realPulseRate, reactivePulseRate;
  wire accumulation_done_irq, frameDoneIrq, test_mux_output, real_energy_pulse, reactive_energy_pulse;
  wire digitalPin6, digitalPin6Enable, digitalPin7, digitalPin7Enable, optical_transmit_pin;
  wire [15:0] realCount, reactiveCount, optCount;
  int miscompares = 0, cmp_count = 0, irqCount = 0;

  epa_energy_pulse epa_energy_pulse_inst (.*);
  epa_pulse_meter epa_pulse_meter_inst (.mclk, .reset, .pin6(digitalPin6), .pin6Enable(digitalPin6Enable),
    .pin7(digitalPin7), .pin7Enable(digitalPin7Enable), .optPin(optical_transmit_pin), .realCount, .reactiveCount,
    .optCount);

  // Main clock and a test clock at one eighth of its rate
  always #20 mclk = ~mclk;
  always @(negedge mclk) tcDiv <= tcDiv + 3'h1;
  // Done pulses counted for deltas
  always @(posedge mclk) if (accumulation_done_irq === 1'b1) irqCount <= irqCount + 1;

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  // One-cycle write; address held for readback
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cfgAddr = a;
    cfgWdata = d;
    cfgWrite = 1'b1;
    cyc(1);
    cfgWrite = 1'b0;
    cyc(2);
  endtask
  // One export; outputs settle two edges later
  task automatic emit(input logic [1:0] b);
    signBits = b;
    signExport = 1'b1;
    cyc(1);
    signExport = 1'b0;
    cyc(2);
  endtask
  task automatic syncRise();
    muxSync = 1'b0;
    cyc(1);
    muxSync = 1'b1;
    cyc(1);
  endtask
  // Done pulse must wait for the last sample
  task automatic accum(input logic [7:0] cfg, input int n);
    int base;
    wr(16'h2001, cfg);
    base = irqCount;
    for (int i = 1; i <= n; i++)
    begin
      if (i == n)
        chk(irqCount - base, 0, "irq early");
      sampleDone = 1'b1;
      cyc(1);
      sampleDone = 1'b0;
      cyc(1);
    end
    cyc(2);
    chk(irqCount - base, 1, "irq missing");
  endtask
  // Sample monitor at the end of each bit, before each test clock rise
  task automatic mon(input logic en, input int expOnes);
    int ones = 0, first = -1, second = -1, last = -1;
    monitor_enable = en;
    syncRise();
    for (int k = 0; k < 200; k++)
    begin
      do cyc(1); while (tcDiv != 3'h3);
      if (test_mux_output === 1'b1)
      begin
        ones++;
        if (first < 0)
          first = k;
        else if (second < 0)
          second = k;
        last = k;
      end
    end
    chk(ones, expOnes, "monitor ones");
    if (en)
    begin
      chk(second - first, 3, "msb place");
      chk(last - first, 108, "flag 4 place");
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 30000 cycles
  initial
  begin
    #1200000;
    miscompares++;
    summarize();
  end

  initial
  begin
    logic [15:0] b6, b7, bo;
    cyc(2);
    reset = 1'b0;
    cyc(1);
    chk(real_energy_pulse, 1, "reset idle");
    chk(cfgRdata, `EPA_ACCCFG_RESET, "cfg reset");
    for (int i = 0; i < 3; i++)
    begin
      {meter_equation_select, external_pulse_flag} = {rows[i].eq, rows[i].ext};
      {voltageA, voltageB, currentA, currentB} = {rows[i].va, rows[i].vb, rows[i].ia, rows[i].ib};
      cyc(3);
      chk(element0Product, rows[i].e0, "elem0");
      chk(element1Product, rows[i].e1, "elem1");
      chk(realPulseRate, rows[i].rr, "real rate");
      chk(reactivePulseRate, rows[i].qr, "react rate");
    end
    done("table");
    muxFrameEnd = 1'b1;
    cyc(1);
    muxFrameEnd = 1'b0;
    accum(8'h02, 84);
    chk(secondLevelSum, 32'hFFFF_343C, "level two sum");
    accum(8'hC0, 100);
    wr(16'h2002, 8'h5A);
    chk(cfgRdata, 8'h00, "unmapped read");
    cfgAddr = 16'h2001;
    cyc(2);
    chk(cfgRdata, 8'hC0, "config kept");
    done("accumulation");
    mon(1'b0, 0);
    mon(1'b1, 12);
    monitor_enable = 1'b0;
    done("monitor");
    real_pulse_route = 1'b1;
    reactive_pulse_route = 1'b1;
    for (int o = 0; o < 3; o++)
    begin
      optical_transmit_enable = o[1:0];
      {b6, b7, bo} = {realCount, reactiveCount, optCount};
      emit(2'h1);
      chk(digitalPin6, 0, "bypass update");
      emit(2'h0);
      emit(2'h2);
      emit(2'h0);
      chk(realCount - b6, 1, "pin6 pulses");
      chk(reactiveCount - b7, 1, "pin7 pulses");
      chk(optCount - bo, (o == 0) ? 0 : 1, "optical pulses");
    end
    pulse_polarity_invert = 1'b1;
    emit(2'h1);
    chk(real_energy_pulse, 1, "inverted");
    pulse_polarity_invert = 1'b0;
    emit(2'h0);
    done("bypass");
    pulse_width_limit = 8'h01;
    repeat (3) emit(2'h1);
    chk(real_energy_pulse, 0, "in limit");
    emit(2'h1);
    chk(real_energy_pulse, 1, "limited");
    pulse_width_limit = 8'hFF;
    repeat (4) emit(2'h1);
    chk(real_energy_pulse, 0, "no limit");
    emit(2'h0);
    done("width");
    pulse_update_interval = 8'h51;
    syncRise();
    b6 = realCount;
    emit(2'h1);
    emit(2'h0);
    emit(2'h1);
    ceHalt = 1'b1;
    cyc(1);
    ceHalt = 1'b0;
    cyc(1000);
    chk(real_energy_pulse, 1, "paced early");
    cyc(5000);
    chk(realCount - b6, 2, "paced pulses");
    pulse_update_interval = 8'h00;
    emit(2'h0);
    pulse_update_interval = 8'h01;
    syncRise();
    emit(2'h1);
    emit(2'h1);
    syncRise();
    cyc(100);
    chk(real_energy_pulse, 1, "frame clear");
    done("paced");
    pulse_update_interval = 8'h00;
    emit(2'h1);
    reset = 1'b1;
    cyc(2);
    chk(real_energy_pulse, 1, "in reset");
    reset = 1'b0;
    cyc(2);
    chk(cfgRdata, `EPA_ACCCFG_RESET, "cfg reset 2");
    done("reset");
    summarize();
  end
endmodule
